// ---- hdl/pdgr_pkg.sv ----
`default_nettype none
package pdgr_pkg;
    // Geometry
    localparam int NCH = 4;
    localparam int NPER = 4;
    localparam int AW = 12;
    localparam int SELW = 4;
    // Register byte offsets
    localparam logic [11:0] OFF_GCTL = 12'h000;
    localparam logic [11:0] OFF_ROUTE = 12'h004;
    localparam logic [11:0] OFF_SPAN0 = 12'h038;
    localparam logic [11:0] SPAN_BYTES = 12'h010;
    // Global control fields
    localparam int GCTL_SRST_BIT = 0;
    localparam int GCTL_CKEN_LSB = 8;
    // Route field positions, peripheral order:
    // audio serial, first uart, pwm audio / sigma delta, first spi
    localparam int RT_TX_LSB [NPER] = '{28, 20, 12, 4};
    localparam int RT_RX_LSB [NPER] = '{24, 16, 8, 0};
    // Reset values
    localparam logic [31:0] GCTL_RST = 32'h0000_0000;
    localparam logic [31:0] ROUTE_RST = 32'h0fff_ffff;
    localparam logic [7:0] SPAN_RST = 8'h00;
    // Soft reset lifetime in clk_sys cycles
    localparam logic [2:0] SRST_CYC = 3'h4;
endpackage
`default_nettype wire

// ---- hdl/pdgr_ctrl.sv ----
// Our own choice: the APB interface to the registers.
`default_nettype none
// Notes on behaviour
// - Offset is read-only, resets to zero
// - Bits 11:8 enable channel clocks 3..0
// - Soft reset clears channel state, not registers
// - Writing zero to soft reset does nothing
// - Soft reset bit clears itself shortly
// - Soft reset hits all channels together
// - Request routed to channel named in field
// - Audio serial tx 31:28, rx 27:24
// - First uart tx 23:20, rx 19:16
// - Pwm audio tx 15:12, sigma delta 11:8
// - First spi tx 7:4, rx 3:0
// - All ones routes nowhere; resets to 0fff_ffff, audio serial tx field zero
// - Spanned mode adds signed increment per transfer
module pdgr_ctrl
    import pdgr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Peripheral request pins
    input wire logic [NPER-1:0] per_tx_req,
    input wire logic [NPER-1:0] per_rx_req,
    // Routed requests towards channels
    output logic [NCH-1:0] chan_dst_req,
    output logic [NCH-1:0] chan_src_req,
    // Channel gating and global reset
    output logic [NCH-1:0] chan_clk_en,
    output logic chan_soft_rst,
    // Channel engine progress
    input wire logic [NCH-1:0] chan_start,
    input wire logic [NCH-1:0] chan_xfer,
    input wire logic [NCH-1:0] chan_src_span,
    input wire logic [NCH-1:0] chan_dst_span,
    input wire logic [NCH*8-1:0] chan_span_incr,
    input wire logic [NCH*32-1:0] chan_base,
    // Current channel address
    output logic [NCH*32-1:0] chan_addr
);

    ////////////////////////////////////////////////////////////////
    // Registers
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [NCH-1:0] cken_q;
    logic [31:0] rt_q;
    logic [2:0] srst_cnt_q;
    logic [2:0] srst_cnt_d;
    logic srst_q;
    logic [NPER-1:0] tx_s1_q;
    logic [NPER-1:0] tx_s2_q;
    logic [NPER-1:0] rx_s1_q;
    logic [NPER-1:0] rx_s2_q;
    logic [NCH-1:0] dst_req_q;
    logic [NCH-1:0] src_req_q;

    ////////////////////////////////////////////////////////////////
    // Bus decode
    wire setup = psel & ~penable;
    wire acc_done = psel & penable & pready_q;
    wire wr_en = acc_done & pwrite;
    wire sel_gctl = (paddr == OFF_GCTL);
    wire sel_route = (paddr == OFF_ROUTE);
    wire [AW-1:0] sp_off = paddr - OFF_SPAN0;
    wire sel_span = (paddr >= OFF_SPAN0) &&
        (sp_off < SPAN_BYTES) && (paddr[1:0] == 2'b00);
    wire [1:0] sp_idx = sp_off[3:2];
    wire mapped = sel_gctl | sel_route | sel_span;
    wire gctl_wr = wr_en & sel_gctl;

    // Soft reset reads back as busy until it expires
    wire [31:0] gctl_rd = {20'h0, cken_q, 7'h0, srst_q};
    wire [NCH*8-1:0] span_w;
    wire [7:0] span_sel = span_w[sp_idx*8 +: 8];
    wire [31:0] rd_w = sel_gctl ? gctl_rd :
        sel_route ? rt_q :
        sel_span ? {24'h0, span_sel} : 32'h0;

    ////////////////////////////////////////////////////////////////
    // APB answer: data latched at setup, ready in access phase.
    // One wait-free access cycle keeps prdata straight from a flop.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup & ~mapped;
            if (setup) begin
                prdata_q <= rd_w;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Control registers; a soft reset leaves them untouched
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cken_q <= GCTL_RST[GCTL_CKEN_LSB +: NCH];
            rt_q <= ROUTE_RST;
        end else begin
            if (gctl_wr) begin
                cken_q <= pwdata[GCTL_CKEN_LSB +: NCH];
            end
            if (wr_en & sel_route) begin
                rt_q <= pwdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Soft reset pulse; a one arms it, a zero is ignored.
    // Writing one again while busy does not stretch it.
    assign srst_cnt_d =
        (gctl_wr && pwdata[GCTL_SRST_BIT] && srst_cnt_q == 3'h0) ?
        SRST_CYC :
        (srst_cnt_q != 3'h0) ? srst_cnt_q - 3'h1 : 3'h0;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            srst_cnt_q <= 3'h0;
            srst_q <= GCTL_RST[GCTL_SRST_BIT];
        end else begin
            srst_cnt_q <= srst_cnt_d;
            srst_q <= (srst_cnt_d != 3'h0);
        end
    end

    ////////////////////////////////////////////////////////////////
    // Request pins come from other clock domains
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tx_s1_q <= '0;
            tx_s2_q <= '0;
            rx_s1_q <= '0;
            rx_s2_q <= '0;
        end else begin
            tx_s1_q <= per_tx_req;
            tx_s2_q <= tx_s1_q;
            rx_s1_q <= per_rx_req;
            rx_s2_q <= rx_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Routing matrix: a field only matches channels 0..3,
    // so values 4..15, all ones among them, route nowhere.
    wire [NCH*NPER-1:0] tx_hit;
    wire [NCH*NPER-1:0] rx_hit;
    wire [NCH-1:0] dst_any;
    wire [NCH-1:0] src_any;

    genvar c;
    genvar p;
    generate
        for (c = 0; c < NCH; c++) begin : g_rt
            for (p = 0; p < NPER; p++) begin : g_per
                // Tx feeds destination, rx feeds source
                assign tx_hit[c*NPER+p] = tx_s2_q[p] &
                    (rt_q[RT_TX_LSB[p] +: SELW] == SELW'(c));
                assign rx_hit[c*NPER+p] = rx_s2_q[p] &
                    (rt_q[RT_RX_LSB[p] +: SELW] == SELW'(c));
            end
            assign dst_any[c] = |tx_hit[c*NPER +: NPER];
            assign src_any[c] = |rx_hit[c*NPER +: NPER];
        end
    endgenerate
    // Field layout for the remaining pairs lives in RT_*_LSB

    // Gated or resetting channels see no request
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            dst_req_q <= '0;
            src_req_q <= '0;
        end else begin
            dst_req_q <= dst_any & cken_q & ~{NCH{srst_q}};
            src_req_q <= src_any & cken_q & ~{NCH{srst_q}};
        end
    end

    ////////////////////////////////////////////////////////////////
    // Per channel span tracking
    generate
        for (c = 0; c < NCH; c++) begin : g_ch
            logic [7:0] off_q;
            logic [31:0] adr_q;
            wire [7:0] incr = chan_span_incr[c*8 +: 8];
            wire spanned = chan_src_span[c] | chan_dst_span[c];
            wire [31:0] incr_x = {{24{incr[7]}}, incr};

            // Soft reset wins over any engine event
            always_ff @(posedge clk_sys or negedge rst_b) begin
                if (!rst_b) begin
                    off_q <= SPAN_RST;
                    adr_q <= 32'h0;
                end else if (srst_q) begin
                    off_q <= SPAN_RST;
                    adr_q <= 32'h0;
                end else if (cken_q[c]) begin
                    if (chan_start[c]) begin
                        off_q <= SPAN_RST;
                        adr_q <= chan_base[c*32 +: 32];
                    end else if (chan_xfer[c] && spanned) begin
                        off_q <= off_q + incr;
                        adr_q <= adr_q + incr_x;
                    end
                end
            end

            assign span_w[c*8 +: 8] = off_q;
            assign chan_addr[c*32 +: 32] = adr_q;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////
    // Outputs
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign chan_dst_req = dst_req_q;
    assign chan_src_req = src_req_q;
    assign chan_clk_en = cken_q;
    assign chan_soft_rst = srst_q;

    ////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    a_srst_one_arms:
    assert property (gctl_wr && pwdata[0] && !srst_q
        |=> srst_q [*4] ##1 !srst_q)
    else $error("soft reset pulse length wrong");

    a_srst_zero_idle:
    assert property (gctl_wr && !pwdata[0] && !srst_q
        |=> !srst_q)
    else $error("zero write started soft reset");

    a_srst_self_clr:
    assert property (srst_q |-> ##[1:5] !srst_q)
    else $error("soft reset did not clear");

    a_srst_keep_ctl:
    assert property (srst_q && !gctl_wr |=> $stable(cken_q))
    else $error("soft reset changed control bits");

    a_srst_all_ch:
    assert property (srst_q |=> span_w == '0
        && chan_dst_req == '0 && chan_src_req == '0)
    else $error("soft reset missed a channel");

    a_gate_no_req:
    assert property (!cken_q[2] |=> !chan_dst_req[2]
        && !chan_src_req[2])
    else $error("gated channel got a request");

    a_gate_hold:
    assert property (!cken_q[1] && !srst_q
        |=> $stable(g_ch[1].off_q) && $stable(g_ch[1].adr_q))
    else $error("gated channel moved");

    a_route_pwm3:
    assert property (rt_q[15:12] == 4'h3 && tx_s2_q[2]
        && cken_q[3] && !srst_q |=> chan_dst_req[3])
    else $error("pwm audio tx not routed");

    a_route_spi_rx:
    assert property (rt_q[3:0] == 4'h0 && rx_s2_q[3]
        && cken_q[0] && !srst_q |=> chan_src_req[0])
    else $error("spi rx not routed");

    // Reset value leaves the audio tx field at zero, so test all ones
    a_route_none:
    assert property (rt_q == 32'hffff_ffff |=> chan_dst_req == '0
        && chan_src_req == '0)
    else $error("all ones route reached a channel");

    a_span_add:
    assert property (cken_q[0] && !srst_q && !chan_start[0]
        && chan_xfer[0] && (chan_src_span[0] | chan_dst_span[0])
        |=> g_ch[0].off_q ==
        8'($past(g_ch[0].off_q) + $past(chan_span_incr[7:0])))
    else $error("span offset not advanced");

    a_span_rd:
    assert property (setup && paddr == OFF_SPAN0
        |=> prdata == {24'h0, $past(g_ch[0].off_q)})
    else $error("span read back wrong");

    a_apb_ready:
    assert property (setup |=> pready ##1 !pready)
    else $error("apb ready timing wrong");

    a_gate_bits:
    assert property (gctl_wr |=> chan_clk_en == $past(pwdata[11:8]))
    else $error("clock gate bits not written");

    a_span_rd_only:
    assert property (wr_en && sel_span && !srst_q && chan_start == '0
        && chan_xfer == '0 |=> $stable(span_w))
    else $error("span offset took a bus write");

    a_route_uart_tx:
    assert property (rt_q[23:20] == 4'h1 && tx_s2_q[1]
        && cken_q[1] && !srst_q |=> chan_dst_req[1])
    else $error("uart tx not routed");

    a_route_aud_rx:
    assert property (rt_q[27:24] == 4'h2 && rx_s2_q[0]
        && cken_q[2] && !srst_q |=> chan_src_req[2])
    else $error("audio serial rx not routed");

    a_route_beyond:
    assert property (rt_q[31:30] != 2'h0 && rt_q[23:22] != 2'h0
        && rt_q[15:14] != 2'h0 && rt_q[7:6] != 2'h0
        |=> chan_dst_req == '0)
    else $error("out of range field reached a channel");

    c_srst: cover property (gctl_wr && pwdata[0] ##1 srst_q);
    c_route: cover property (chan_dst_req[3] && chan_src_req[0]);
    c_span: cover property (chan_xfer[0] ##1 g_ch[0].off_q[7]);
    c_err: cover property (pready && pslverr);
    c_gated: cover property (!cken_q[2] && dst_any[2]);

endmodule
`default_nettype wire

// ---- dv/pdgr_periph_model.sv ----
`default_nettype none
module pdgr_periph_model
    import pdgr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Fifo state set by the bench
    input wire logic [NPER-1:0] tx_room,
    input wire logic [NPER-1:0] rx_ready,
    // Request pins
    output logic [NPER-1:0] per_tx_req,
    output logic [NPER-1:0] per_rx_req
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////
    // Registered pins, so requests lag the fifo state by one cycle
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            per_tx_req <= '0;
            per_rx_req <= '0;
        end else begin
            per_tx_req <= tx_room;
            per_rx_req <= rx_ready;
        end
    end
endmodule
`default_nettype wire

// ---- dv/pdgr_ctrl_bench.sv ----
`default_nettype none
module pdgr_ctrl_bench
    import pdgr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
    logic [AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rv, r;
    logic pready, pslverr, e;
    logic [3:0] tx_room = '0, rx_ready = '0, ptx, prx, fv, ev;
    logic [3:0] dreq, sreq, cken, cst = '0, cxf = '0;
    logic srst;
    logic [127:0] caddr;
    int fails = 0, comparisons = 0, cyc = 0, srst_cnt = 0, s0;

    // Free-running clock at 250 MHz
    always #2 clk_sys = ~clk_sys;

    pdgr_periph_model pdgr_periph_model_i (.clk_sys(clk_sys),
        .rst_b(rst_b), .tx_room(tx_room), .rx_ready(rx_ready),
        .per_tx_req(ptx), .per_rx_req(prx));
    pdgr_ctrl pdgr_ctrl_i (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .per_tx_req(ptx), .per_rx_req(prx),
        .chan_dst_req(dreq), .chan_src_req(sreq), .chan_clk_en(cken),
        .chan_soft_rst(srst), .chan_start(cst), .chan_xfer(cxf),
        .chan_src_span(4'h1), .chan_dst_span(4'h2),
        .chan_span_incr({4{8'hfc}}), .chan_base({4{32'h0000_1000}}),
        .chan_addr(caddr));

    ////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; the request holds until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // No fixed wait; only the cycle ceiling ends a hang
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                      input string what);
        apb(1'b0, a, 32'h0);
        chk(what, exp, r);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // Cycle ceiling, and a tally of soft reset cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (srst === 1'b1) srst_cnt++;
        if (cyc == 20000) begin
            fails++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        tick(20);
        rst_b <= 1'b1;
        rd(OFF_GCTL, 32'h0, "gctl rst");
        rd(OFF_ROUTE, 32'h0fff_ffff, "route rst");
        for (int c = 0; c < 4; c++) begin
            rd(OFF_SPAN0 + 12'(4 * c), 32'h0, "span");
        end
        apb(1'b1, 12'h100, 32'h1);
        chk("err wr", 1, e);
        apb(1'b0, 12'h100, 32'h0);
        chk("err rd", 32'h1, {31'h0, e});
        chk("unmapped data", 0, r);
        apb(1'b1, OFF_GCTL, 32'h0f00);
        // The write lands on the edge the task returns at
        tick(1);
        chk("cken", 4'hf, 32'(cken));
        // Every peripheral, field values 0..5 (4 and 5 beyond range) and all ones
        for (int p = 0; p < 4; p++) begin
            for (int v = 0; v < 7; v++) begin
                fv = (v == 6) ? 4'hf : 4'(v);
                rv = 32'hffff_ffff;
                rv[28-8*p +: 4] = fv;
                rv[24-8*p +: 4] = fv;
                apb(1'b1, OFF_ROUTE, rv);
                rd(OFF_ROUTE, rv, "route");
                tx_room <= 4'(1 << p);
                rx_ready <= 4'(1 << p);
                tick(6);
                ev = (fv < 4) ? 4'(1 << fv) : 4'h0;
                chk("dst req", 32'(ev), 32'(dreq));
                chk("src req", 32'(ev), 32'(sreq));
                tx_room <= '0;
                rx_ready <= '0;
                tick(6);
            end
        end
        // Gated channel drops its routed request
        apb(1'b1, OFF_ROUTE, 32'hffff_ff2f);
        apb(1'b1, OFF_GCTL, 32'h0b00);
        tx_room <= 4'h8;
        tick(6);
        chk("gated req", 0, 32'(dreq));
        apb(1'b1, OFF_GCTL, 32'h0f00);
        tick(6);
        chk("ungated req", 4'h4, 32'(dreq));
        tx_room <= '0;
        // Load channels 0 and 1, two spanned transfers of -4
        @(posedge clk_sys);
        cst <= 4'h3;
        @(posedge clk_sys);
        cst <= 4'h0;
        cxf <= 4'h7;
        tick(2);
        cxf <= 4'h0;
        apb(1'b1, OFF_GCTL, 32'h0d00);
        tick(1);
        chk("cken", 4'hd, 32'(cken));
        cxf <= 4'h3;
        @(posedge clk_sys);
        cxf <= 4'h0;
        rd(12'h038, 32'hf4, "span0");
        rd(12'h03c, 32'hf8, "span1 gated");
        rd(12'h040, 32'h0, "span2 plain");
        chk("addr0", 32'h0ff4, caddr[31:0]);
        chk("addr1", 32'h0ff8, caddr[63:32]);
        apb(1'b1, 12'h038, 32'h55);
        chk("span wr err", 0, e);
        s0 = srst_cnt;
        apb(1'b1, OFF_GCTL, 32'h0f00);
        rd(12'h038, 32'hf4, "span0 kept");
        chk("no srst", s0, srst_cnt);
        // Soft reset: self-clearing, channels 0 and 1 cleared, registers kept
        apb(1'b1, OFF_GCTL, 32'h0f01);
        rd(OFF_GCTL, 32'h0f01, "srst busy");
        tick(8);
        chk("srst len", 32'(SRST_CYC), srst_cnt - s0);
        rd(OFF_GCTL, 32'h0f00, "gctl kept");
        rd(OFF_ROUTE, 32'hffff_ff2f, "route kept");
        rd(12'h038, 0, "span0 cleared");
        rd(12'h03c, 0, "span1 cleared");
        chk("addr0 cleared", 0, caddr[31:0]);
        print_verdict();
    end
endmodule
`default_nettype wire
